/* File: hdl/cifd_map.vh */
// constants for the instruction field decoder
`ifndef CIFD_MAP_VH
`define CIFD_MAP_VH
`define CIFD_EA_REG_DIRECT   4'hA
`define CIFD_EA_REG_IND      4'hD
`define CIFD_EA_DISP8        4'hE
`define CIFD_EA_DISP16       4'hF
`define CIFD_EA_PREDEC       4'hB
`define CIFD_EA_POSTINC      4'hC
`define CIFD_EA_ABS8         4'h0
`define CIFD_EA_ABS16        4'h1
`define CIFD_EA_ABS_REG      3'h5
`define CIFD_EA_IMM8         8'h04
`define CIFD_EA_IMM16        8'h0C
`define CIFD_MODE_NONE       4'h0
`define CIFD_MODE_RN         4'h1
`define CIFD_MODE_IND        4'h2
`define CIFD_MODE_D8         4'h3
`define CIFD_MODE_D16        4'h4
`define CIFD_MODE_PRE        4'h5
`define CIFD_MODE_POST       4'h6
`define CIFD_MODE_AA8        4'h7
`define CIFD_MODE_AA16       4'h8
`define CIFD_MODE_IMM8       4'h9
`define CIFD_MODE_IMM16      4'hA
`define CIFD_CR_SR           3'h0
`define CIFD_CR_CCR          3'h1
`define CIFD_CR_BR           3'h3
`define CIFD_CR_EP           3'h4
`define CIFD_CR_DP           3'h5
`define CIFD_CR_TP           3'h7
`define CIFD_CRSEL_NONE      3'h0
`define CIFD_CRSEL_SR        3'h1
`define CIFD_CRSEL_CCR       3'h2
`define CIFD_CRSEL_BR        3'h3
`define CIFD_CRSEL_EP        3'h4
`define CIFD_CRSEL_DP        3'h5
`define CIFD_CRSEL_TP        3'h6
`define CIFD_VEC_BASE_MIN    16'h0020
`define CIFD_VEC_BASE_MAX    16'h0040
`define CIFD_OP_TRAP_ALWAYS        8'h08
`define CIFD_OP_TRAPVS       8'h09
`define CIFD_OP_LDM          8'h02
`define CIFD_OP_STM          8'h12
`endif

/* File: hdl/cifd_vector_table.v */
// trap vector number to vector table entry address lookup
`timescale 1ns/1ps
module cifd_vector_table (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire [3:0]  vec_num,
	input  wire        max_mode,
	output reg  [15:0] vec_addr
);
`include "cifd_map.vh"
	// registered lookup; two byte entries in min mode, four in max mode
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			vec_addr <= 16'h0000;
		end else if (max_mode) begin
			vec_addr <= `CIFD_VEC_BASE_MAX + {10'h000, vec_num, 2'h0};
		end else begin
			vec_addr <= `CIFD_VEC_BASE_MIN + {11'h000, vec_num, 1'h0};
		end
	end
endmodule // cifd_vector_table

/* File: hdl/cifd_decoder.v */
// instruction field decoder: operand locator, operation and sub-fields
`timescale 1ns/1ps
`include "cifd_map.vh"
// Summary of operation
// - general format: operand locator field first, then operation field, decoded together
// - length varies with mode and operation; absent bytes accepted
// - short format: operation byte leads, no separate locator byte
// - size bit zero means byte, one means word
// - three-bit register field picks register 0 to 7; bytes use low half
// - control register field: 000 word status; byte 001,011,100,101,111 others
// - register list bit n selects general register n
// - trap carries four-bit vector number 0 to 15
// - vector address 0x20+2n minimum mode, 0x40+4n maximum mode
// - overflow trap taken only when overflow flag is one
// - locator byte encodes addressing mode by fixed bit patterns
module cifd_decoder (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        insn_valid,
	input  wire [7:0]  byte0,
	input  wire [7:0]  byte1,
	input  wire [7:0]  byte2,
	input  wire [7:0]  byte3,
	input  wire        max_mode,
	input  wire        overflow_flag,
	output reg         dec_valid,
	output reg         short_format,
	output reg  [3:0]  addr_mode,
	output reg         operand_size_bit,
	output reg  [2:0]  gen_reg_num,
	output reg  [2:0]  op_reg_num,
	output reg  [7:0]  operation_field,
	output reg  [7:0]  operand_locator_field,
	output reg  [2:0]  ctrl_reg_sel,
	output reg         ctrl_reg_bad,
	output reg  [7:0]  reg_select,
	output reg         is_load,
	output reg  [2:0]  insn_length,
	output reg  [3:0]  trap_vector_num,
	output reg         trap_take,
	output wire [15:0] trap_vec_addr
);
	// combinational decode results
	reg        c_short;
	reg [3:0]  c_mode;
	reg [2:0]  c_ea_len;
	reg [7:0]  c_op;
	reg [2:0]  c_cr;
	reg        c_crbad;
	reg [2:0]  c_len;
	reg        c_trap;
	reg [3:0]  c_vec;
	reg [7:0]  c_list;
	wire       sz = byte0[3];
	reg        c_load; // high for a load, low for a store
	wire       list_op;
	wire [7:0] list_bits;

	// multiple load and store: the list byte follows the leading operation byte
	assign list_op = (byte0 == `CIFD_OP_LDM) || (byte0 == `CIFD_OP_STM);

	// one select line per general register, bit n picks register n
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_list
			assign list_bits[gi] = list_op & byte1[gi];
		end
	endgenerate

	// short formats lead with 01000 or 01010..10011 patterns in the top five bits
	always @* begin
		c_short = (byte0[7:4] == 4'h5) || (byte0[7:4] == 4'h6) || (byte0[7:4] == 4'h7)
			|| (byte0[7:4] == 4'h8) || (byte0[7:3] == 5'h08) || (byte0[7:4] == 4'h9);
		c_short = c_short || (byte0[7:3] == 5'h08);
		c_mode = `CIFD_MODE_NONE;
		c_ea_len = 3'h1;
		// addressing mode from the locator byte
		case (byte0[7:4])
			`CIFD_EA_REG_DIRECT: c_mode = `CIFD_MODE_RN;
			`CIFD_EA_REG_IND: c_mode = `CIFD_MODE_IND;
			`CIFD_EA_DISP8: begin
				c_mode = `CIFD_MODE_D8;
				c_ea_len = 3'h2;
			end
			`CIFD_EA_DISP16: begin
				c_mode = `CIFD_MODE_D16;
				c_ea_len = 3'h3;
			end
			`CIFD_EA_PREDEC: c_mode = `CIFD_MODE_PRE;
			`CIFD_EA_POSTINC: c_mode = `CIFD_MODE_POST;
			`CIFD_EA_ABS8: begin
				if (byte0 == `CIFD_EA_IMM8) begin
					c_mode = `CIFD_MODE_IMM8;
					c_ea_len = 3'h2;
				end else if (byte0[2:0] == `CIFD_EA_ABS_REG) begin
					c_mode = `CIFD_MODE_AA8;
					c_ea_len = 3'h2;
				end
			end
			`CIFD_EA_ABS16: begin
				if (byte0[2:0] == `CIFD_EA_ABS_REG) begin
					c_mode = `CIFD_MODE_AA16;
					c_ea_len = 3'h3;
				end
			end
			default: begin
				if (byte0 == `CIFD_EA_IMM16) begin
					c_mode = `CIFD_MODE_IMM16;
					c_ea_len = 3'h3;
				end
			end
		endcase
		// the 16-bit immediate code shares the absolute-8 nibble, so patch it here
		if (byte0 == `CIFD_EA_IMM16) begin
			c_mode = `CIFD_MODE_IMM16;
			c_ea_len = 3'h3;
		end
		// a recognised locator pattern always overrides the short-format guess
		if (c_mode != `CIFD_MODE_NONE) begin
			c_short = 1'b0;
		end
		// operation byte follows the locator unless the short form leads
		if (c_short) begin
			c_op = byte0;
		end else if (c_ea_len == 3'h1) begin
			c_op = byte1;
		end else if (c_ea_len == 3'h2) begin
			c_op = byte2;
		end else begin
			c_op = byte3;
		end
		// total length: locator bytes plus operation byte, plus one or two bytes by size for op 06 outside register direct; short forms by pattern
		if (c_short) begin
			c_len = (byte0[7:3] == 5'h0B) ? 3'h3 : 3'h2;
		end else if (c_op == 8'h06 && c_mode != `CIFD_MODE_RN) begin
			c_len = c_ea_len + (sz ? 3'h3 : 3'h2);
		end else begin
			c_len = c_ea_len + 3'h1;
		end
		// control register field decode with size qualification
		c_cr = `CIFD_CRSEL_NONE;
		c_crbad = 1'b0;
		case (c_op[2:0])
			`CIFD_CR_SR: c_cr = sz ? `CIFD_CRSEL_SR : `CIFD_CRSEL_NONE;
			`CIFD_CR_CCR: c_cr = sz ? `CIFD_CRSEL_NONE : `CIFD_CRSEL_CCR;
			`CIFD_CR_BR: c_cr = sz ? `CIFD_CRSEL_NONE : `CIFD_CRSEL_BR;
			`CIFD_CR_EP: c_cr = sz ? `CIFD_CRSEL_NONE : `CIFD_CRSEL_EP;
			`CIFD_CR_DP: c_cr = sz ? `CIFD_CRSEL_NONE : `CIFD_CRSEL_DP;
			`CIFD_CR_TP: c_cr = sz ? `CIFD_CRSEL_NONE : `CIFD_CRSEL_TP;
			default: c_cr = `CIFD_CRSEL_NONE;
		endcase
		// the datapath must not trust ctrl_reg_sel while the bad flag stands
		c_crbad = (c_cr == `CIFD_CRSEL_NONE); // flagged only, no defined result
		// trap decoding: always trap or overflow-conditional trap
		c_vec = byte1[3:0];
		c_trap = 1'b0;
		if (byte0 == `CIFD_OP_TRAP_ALWAYS) begin
			c_trap = 1'b1;
		end else if (byte0 == `CIFD_OP_TRAPVS) begin
			c_trap = overflow_flag;
		end
		// register list byte for multiple load and store, zero otherwise
		c_list = list_bits;

		// list transfers carry the direction in the leading byte, others in the op byte
		if (list_op) begin
			c_load = ~byte0[4];
		end else begin
			c_load = ~c_op[4];
		end
	end

	// vector address lookup, registered alongside the other fields
	cifd_vector_table u_vec (
		.core_clk (core_clk),
		.rstn     (rstn),
		.vec_num  (c_vec),
		.max_mode (max_mode),
		.vec_addr (trap_vec_addr)
	);

	// register all decoded fields one cycle after the instruction is offered
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dec_valid <= 1'b0;
			short_format <= 1'b0;
			addr_mode <= 4'h0;
			operand_size_bit <= 1'b0;
			gen_reg_num <= 3'h0;
			op_reg_num <= 3'h0;
			operation_field <= 8'h00;
			operand_locator_field <= 8'h00;
			ctrl_reg_sel <= 3'h0;
			ctrl_reg_bad <= 1'b0;
			reg_select <= 8'h00;
			// resets high so the slot out of reset reads as a harmless load; later empty slots decode the idle bytes
			is_load <= 1'b1;
			insn_length <= 3'h0;
			trap_vector_num <= 4'h0;
			trap_take <= 1'b0;
		end else begin
			dec_valid <= insn_valid;
			short_format <= c_short;
			addr_mode <= c_mode;
			operand_size_bit <= c_short ? byte0[3] : sz;
			gen_reg_num <= byte0[2:0];
			op_reg_num <= c_op[2:0];
			operation_field <= c_op;
			operand_locator_field <= c_short ? 8'h00 : byte0;
			ctrl_reg_sel <= c_cr;
			ctrl_reg_bad <= c_crbad;
			reg_select <= c_list;
			is_load <= c_load;
			insn_length <= c_len;
			trap_vector_num <= c_vec;
			// trap request only for an offered instruction, never for idle bytes
			trap_take <= insn_valid & c_trap;
		end
	end
endmodule // cifd_decoder

/* File: verification/cifd_fetch_model.sv */
// fetch-side model presenting instruction starts to the decoder
`timescale 1ns/1ps
module cifd_fetch_model (
	input  wire        core_clk,
	input  wire [31:0] req_word,
	input  wire        req_valid,
	output wire        insn_valid,
	output wire [7:0]  byte0,
	output wire [7:0]  byte1,
	output wire [7:0]  byte2,
	output wire [7:0]  byte3
);
	reg [31:0] idle = 32'h0;
	// released bytes flip each cycle so stale data never looks held
	always @(negedge core_clk) idle <= ~idle;
	// bytes leave in fetch order, leading byte on byte0
	assign {byte0, byte1, byte2, byte3} = req_valid ? req_word : idle;
	assign insn_valid = req_valid;
endmodule // cifd_fetch_model

/* File: verification/cifd_checker.sv */
// port assertions for the decoder
`timescale 1ns/1ps
module cifd_checker (
	input wire       core_clk,
	input wire       rstn,
	input wire       insn_valid,
	input wire [7:0] byte0,
	input wire [7:0] byte1,
	input wire       overflow_flag,
	input wire       dec_valid,
	input wire       short_format,
	input wire [3:0] addr_mode,
	input wire       operand_size_bit,
	input wire [2:0] gen_reg_num,
	input wire [7:0] operation_field,
	input wire [2:0] insn_length,
	input wire       trap_take
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// locator and trap byte classes
	wire rn = insn_valid && byte0[7:4] == 4'hA;
	wire ind = insn_valid && byte0[7:4] == 4'hD;
	wire tv = insn_valid && byte0 == 8'h09;
	chk_valid_delay: assert property (insn_valid |=> dec_valid) else $error("valid");
	chk_mode_rn: assert property (rn |=> addr_mode == 4'h1) else $error("mode");
	chk_size_bit: assert property (rn |=> operand_size_bit == $past(byte0[3])) else $error("sz");
	chk_gen_reg: assert property (rn |=> gen_reg_num == $past(byte0[2:0])) else $error("reg");
	chk_len_two: assert property (rn |=> insn_length == 3'h2) else $error("len");
	chk_op_after: assert property (ind |=> operation_field == $past(byte1)) else $error("op");
	chk_short_fmt: assert property (insn_valid && byte0[7:4] == 4'h5 |=> short_format)
		else $error("short");
	chk_ovf_trap: assert property (tv |=> trap_take == $past(overflow_flag)) else $error("trap");
	cover property (tv && overflow_flag);
	cover property (short_format);
	cover property (ind);
endmodule // cifd_checker
bind cifd_decoder cifd_checker i_cifd_checker (.core_clk, .rstn, .insn_valid, .byte0, .byte1,
	.overflow_flag, .dec_valid, .short_format, .addr_mode, .operand_size_bit, .gen_reg_num,
	.operation_field, .insn_length, .trap_take);

/* File: verification/cpu_instruction_field_decoder_bench.sv */
// self-checking bench for the decoder
`timescale 1ns/1ps
module cpu_instruction_field_decoder_bench;
	reg         core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, max_mode = 1'b0, overflow_flag = 1'b0;
	reg  [31:0] req_word = 32'h0;
	wire [7:0]  byte0, byte1, byte2, byte3, operation_field, operand_locator_field, reg_select;
	wire        insn_valid, dec_valid, short_format, operand_size_bit, ctrl_reg_bad, is_load, trap_take;
	wire [3:0]  addr_mode, trap_vector_num;
	wire [2:0]  gen_reg_num, op_reg_num, ctrl_reg_sel, insn_length;
	wire [15:0] trap_vec_addr;
	integer     errors = 0, n_tests = 0, i;
	always #12.5 core_clk = ~core_clk;
	cifd_fetch_model i_cifd_fetch_model (.core_clk, .req_word, .req_valid, .insn_valid,
		.byte0, .byte1, .byte2, .byte3);
	cifd_decoder i_cifd_decoder (.core_clk, .rstn, .insn_valid, .byte0, .byte1, .byte2, .byte3,
		.max_mode, .overflow_flag, .dec_valid, .short_format, .addr_mode, .operand_size_bit,
		.gen_reg_num, .op_reg_num, .operation_field, .operand_locator_field, .ctrl_reg_sel,
		.ctrl_reg_bad, .reg_select, .is_load, .insn_length, .trap_vector_num, .trap_take,
		.trap_vec_addr);
	task cmp(input [15:0] got, input [15:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one instruction start, checked after the decoder registers it
	task send(input [31:0] w);
		@(negedge core_clk);
		req_word <= w;
		req_valid <= 1'b1;
		@(negedge core_clk);
	endtask
	task t_general;
		send(32'hD0210000);
		cmp({addr_mode, insn_length, dec_valid, operation_field}, 16'h2521);
		cmp(operand_locator_field, 8'hD0);
		send(32'h0D112100);
		cmp({addr_mode, insn_length, dec_valid, operation_field}, 16'h7721);
		send(32'hE1052100);
		cmp({addr_mode, insn_length, dec_valid, operation_field}, 16'h3721);
		send(32'h0C123421);
		cmp({addr_mode, insn_length, dec_valid, operation_field}, 16'hA921);
		send(32'hA9210000);
		cmp({operand_size_bit, gen_reg_num, addr_mode}, 8'h91);
		send(32'hA2900000);
		cmp({operand_size_bit, gen_reg_num, 3'h0, is_load}, 8'h20);
		$display("general end");
	endtask
	task t_ctrl;
		send(32'hA8880000);
		cmp({ctrl_reg_bad, ctrl_reg_sel}, 4'h1);
		// only permitted field and size pairs are issued
		for (i = 1; i < 8; i = i + 1)
			if (i != 2 && i != 6) begin
				send({8'hA0, 5'h11, i[2:0], 16'h0});
				cmp(ctrl_reg_sel, i == 1 ? 3'h2 : i == 7 ? 3'h6 : i[2:0]);
				cmp(ctrl_reg_bad, 1'b0);
				cmp(op_reg_num, i[2:0]);
			end
		$display("control end");
	endtask
	task t_list;
		send(32'h12810000);
		cmp({reg_select, 7'h0, is_load}, 16'h8100);
		send(32'h025A0000);
		cmp({reg_select, 7'h0, is_load}, 16'h5A01);
		$display("list end");
	endtask
	task t_trap;
		for (i = 0; i < 32; i = i + 1) begin
			max_mode <= i[4];
			send({12'h080, i[3:0], 16'h0});
			@(negedge core_clk);
			cmp(trap_vector_num, i[3:0]);
			cmp(trap_take, 1'b1);
			cmp(trap_vec_addr, i[4] ? 16'h40 + {i[3:0], 2'h0} : 16'h20 + {i[3:0], 1'h0});
		end
		for (i = 0; i < 2; i = i + 1) begin
			overflow_flag <= i[0];
			send(32'h09000000);
			cmp(trap_take, i[0]);
		end
		$display("trap end");
	endtask
	task t_short;
		send(32'h50120000);
		cmp({short_format, operand_locator_field, 7'h0}, 16'h8000);
		cmp({insn_length, operation_field}, 16'h0250);
		send(32'h58123400);
		cmp({insn_length, operation_field}, 16'h0358);
		req_valid <= 1'b0;
		@(negedge core_clk);
		cmp(dec_valid, 1'b0);
		$display("short end");
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// reset, then each scenario in turn
	initial begin
		repeat (3) @(negedge core_clk);
		rstn <= 1'b1;
		cmp({dec_valid, is_load}, 2'h1);
		t_general;
		t_ctrl;
		t_list;
		t_trap;
		t_short;
		report_and_stop;
	end
	// watchdog well past the roughly 140 cycles the scenarios need
	initial begin
		#20000;
		errors = errors + 1;
		report_and_stop;
	end
endmodule // cpu_instruction_field_decoder_bench
